// *** logic/rtc_map.vh ***
// Register offsets, field positions, reset values and timing for rtc_core
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// Register offsets
`define ADDR_SCRATCH       8'h03
`define ADDR_SECONDS       8'h04
`define ADDR_MINUTES       8'h05
`define ADDR_HOURS         8'h06
`define ADDR_DAYS          8'h07
`define ADDR_WEEKDAYS      8'h08

// Field positions
`define HALT_BIT           7
`define MERIDIEM_BIT       5
`define SIGN_BIT           6

// Reset values
`define RST_SCRATCH        8'h00
`define RST_SECONDS        7'h00
`define RST_MINUTES        7'h00
`define RST_HOURS          6'h00
`define RST_DAYS           6'h01
`define RST_WEEKDAY        3'h6
`define LAST_WEEKDAY       3'h6

// Timing: base rate of the correction slot, spacing of repeated pulses
`define MCLK_HZ            20000000
`define CORR_PULSE_HZ      1024
`define CORR_SPACING_HZ    512
`define SLOTS_PER_SPACING  (`CORR_PULSE_HZ / `CORR_SPACING_HZ)
`define TICK_CYCLES_DFLT   (`MCLK_HZ / `CORR_PULSE_HZ)
`define PRESCALE_TOP       1024
`define SLOT_64HZ_MASK     4'hF
`define SLOT_LIMIT         4'hA
`define CORR_QUARTER_LAST  2'h3

// BCD limits
`define SEC_MIN_LAST       7'h59
`define HOUR24_LAST        6'h23
`define HOUR12_LAST_AM     5'h11
`define HOUR12_NOON        5'h12
`define HOUR12_FIRST       5'h01

`endif

// *** logic/rtc_core.v ***
// Timekeeping core: BCD counters, halt flag, scratch byte, fast correction
`timescale 1ns/10ps
`include "rtc_map.vh"
// Functional notes
// [R1] Fast-mode correction pulse on interrupt lasts 1/1024 s, repeats 1/512 s.
// [R2] Timer ticks 64 Hz and slower are disturbed; the fast base is not.
// [R3] Clock outputs 1024 Hz and up unaffected; the 1 Hz output affected.
// [R4] Scratch byte at 03h, read/write, no other function, resets to zero.
// [R5] Seconds at 04h: tens 0-5 in bits 6-4, units in 3-0, reset 00.
// [R6] Seconds bit 7 is the oscillator halt flag, set on stop, 1 at reset.
// [R7] Oscillator counts as stopped from power-on until stable running.
// [R8] Flag stays set until host clears it; clear fails while stopped.
// [R9] Minutes at 05h BCD tens 0-5, units 0-9, bit 7 reads zero.
// [R10] 12-hour hours at 06h: bit 5 meridiem, bit 4 tens, bits 3-0 units.
// [R11] 24-hour hours: bits 5-4 tens 0-2, bits 3-0 units, bits 7-6 zero.
// [R12] Hour format follows the format-select control bit.
// [R13] Days at 07h BCD tens 0-3, units; resets to 1; bits 7-6 zero.
// [R14] Year divisible by four lets February reach day 29.
// [R15] Weekdays at 08h hold 0-6 in bits 2-0; upper bits read zero.
// [R16] Weekday codes 000 to 110, reset 110; meaning chosen by software.
// [R17] No counting during host access; one pending tick applied afterwards.
// [R18] Fast correction every four minutes, one pulse per second, excess in 59.
// [R19] Correction pulses reach interrupt only when correction enable is 1.
// [R20] Each tick carries seconds into minutes, hours, days, weekdays in BCD.
// [R21] 12-hour count runs 12, 1 to 11; meridiem toggles from 11 to 12.

module rtc_core #(
	parameter TICK_CYCLES = `TICK_CYCLES_DFLT
) (
	// Clock, reset, enable
	input  wire       i_mclk,
	input  wire       i_rst,
	input  wire       i_ce,
	// Register access from the serial interface
	input  wire       i_access_busy,
	input  wire       i_wr_en,
	input  wire       i_rd_en,
	input  wire [7:0] i_addr,
	input  wire [7:0] i_wdata,
	output reg  [7:0] o_rdata,
	// Control bits held in the control and offset registers
	input  wire       i_mode_12h,
	input  wire       i_correction_irq_enable,
	input  wire       i_fast_mode,
	input  wire [6:0] i_offset,
	// Calendar context from the month and year counters
	input  wire       i_leap_year,
	input  wire [4:0] i_month_bcd,
	// Oscillator status pin
	input  wire       i_osc_running,
	// Interrupt pin and derived clocks
	output reg        o_int_n,
	output reg        o_tick_1024hz,
	output reg        o_tick_64hz,
	output reg        o_tick_1hz
);

////////////////////////////////////////////////////////////////////////////

function [7:0] bcd_inc;
	input [7:0] v;
	begin
		if (v[3:0] == 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// State

reg  [7:0]  scratch_byte;
reg  [6:0]  seconds_bcd;
reg         oscillator_halt_flag;
reg  [6:0]  minutes_bcd;
reg  [5:0]  hours_bcd;
reg  [5:0]  days_bcd;
reg  [2:0]  weekday;
reg         pending;
reg  [1:0]  minute_quarter;
reg  [6:0]  corr_left;
reg         corr_add;
reg  [15:0] div_cnt;
reg  [9:0]  prescale;
reg  [3:0]  slot;
reg         osc_s1;
reg         osc_s2;
reg         osc_s3;
reg         osc_ok;

////////////////////////////////////////////////////////////////////////////
// Oscillator status: three stages, a change counts once stages 2 and 3 agree

always @(posedge i_mclk) begin
	if (i_rst) begin
		osc_s1 <= 1'b0;
		osc_s2 <= 1'b0;
		osc_s3 <= 1'b0;
		osc_ok <= 1'b0;
	end else if (i_ce) begin
		osc_s1 <= i_osc_running;
		osc_s2 <= osc_s1;
		osc_s3 <= osc_s2;
		if (osc_s2 == osc_s3)
			osc_ok <= osc_s3; // R7
	end
end

////////////////////////////////////////////////////////////////////////////
// Base tick at the correction slot rate; runs only with a live oscillator

wire base_tick = osc_ok && (div_cnt == TICK_CYCLES - 1);

always @(posedge i_mclk) begin
	if (i_rst)
		div_cnt <= 16'h0000;
	else if (i_ce) begin
		if (!osc_ok || base_tick)
			div_cnt <= 16'h0000;
		else
			div_cnt <= div_cnt + 16'h0001;
	end
end

////////////////////////////////////////////////////////////////////////////
// Correction slot decision

// In second 59 each even slot below 10 may carry a pulse, otherwise only slot 0
wire in_sec59   = (seconds_bcd == `SEC_MIN_LAST);
wire slot_even  = (slot[0] == 1'b0) && (slot < `SLOT_LIMIT);
wire slot_ok    = (slot == 4'h0) || (in_sec59 && slot_even); // R18
wire corr_pulse = base_tick && i_fast_mode && (corr_left != 7'h00)
		&& slot_ok;

// A positive offset adds a slot, a negative one swallows a slot
wire [1:0]  pre_step = !corr_pulse ? 2'h1 : (corr_add ? 2'h2 : 2'h0);
wire [10:0] pre_sum  = {1'b0, prescale} + {9'h000, pre_step};
wire        sec_event = base_tick && pre_sum[10];

wire [6:0] offset_mag = i_offset[`SIGN_BIT]
		? (7'h00 - i_offset) : i_offset;

always @(posedge i_mclk) begin
	if (i_rst) begin
		prescale      <= 10'h000;
		slot          <= 4'h0;
		o_tick_1024hz <= 1'b0;
		o_tick_64hz   <= 1'b0;
		o_tick_1hz    <= 1'b0;
		o_int_n       <= 1'b1;
	end else if (i_ce) begin
		// Fast base is never adjusted, so it and faster clocks stay clean
		o_tick_1024hz <= base_tick; // R3
		o_tick_64hz   <= base_tick &&
				((pre_sum[3:0] & `SLOT_64HZ_MASK) == 4'h0); // R2
		o_tick_1hz    <= sec_event; // R2 R3
		if (base_tick) begin
			prescale <= pre_sum[9:0]; // R2
			if (sec_event)
				slot <= 4'h0;
			else if (slot != 4'hF)
				slot <= slot + 4'h1;
			// Held low for exactly one slot, so 1/1024 s wide
			o_int_n <= !(corr_pulse && i_correction_irq_enable); // R1 R19
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Counter increment

reg [6:0] next_sec;
reg [6:0] next_min;
reg [5:0] next_hour;
reg [5:0] next_day;
reg [2:0] next_wday;
reg [5:0] day_last;
reg       min_carry;
reg       day_carry;
reg [7:0] tmp;

always @* begin
	tmp       = 8'h00;
	next_sec  = seconds_bcd;
	next_min  = minutes_bcd;
	next_hour = hours_bcd;
	next_day  = days_bcd;
	next_wday = weekday;
	min_carry = 1'b0;
	day_carry = 1'b0;
	case (i_month_bcd)
	5'h02:   day_last = i_leap_year ? 6'h29 : 6'h28; // R14
	5'h04,
	5'h06,
	5'h09,
	5'h11:   day_last = 6'h30;
	default: day_last = 6'h31;
	endcase
	if (seconds_bcd == `SEC_MIN_LAST) begin // R20
		next_sec  = 7'h00;
		min_carry = 1'b1;
	end else begin
		tmp      = bcd_inc({1'b0, seconds_bcd});
		next_sec = tmp[6:0]; // R5
	end
	if (min_carry) begin
		if (minutes_bcd == `SEC_MIN_LAST) begin
			next_min = 7'h00;
			if (i_mode_12h) begin // R12
				if (hours_bcd[4:0] == `HOUR12_LAST_AM) begin
					// 11 to 12 flips the half; 11 PM to 12 AM is a new day
					next_hour = {~hours_bcd[`MERIDIEM_BIT],
							`HOUR12_NOON}; // R21 R10
					day_carry = hours_bcd[`MERIDIEM_BIT];
				end else if (hours_bcd[4:0] == `HOUR12_NOON) begin
					next_hour = {hours_bcd[`MERIDIEM_BIT],
							`HOUR12_FIRST}; // R21
				end else begin
					tmp       = bcd_inc({3'h0, hours_bcd[4:0]});
					next_hour = {hours_bcd[`MERIDIEM_BIT], tmp[4:0]};
				end
			end else if (hours_bcd == `HOUR24_LAST) begin
				next_hour = 6'h00; // R11
				day_carry = 1'b1;
			end else begin
				tmp       = bcd_inc({2'h0, hours_bcd});
				next_hour = tmp[5:0]; // R11
			end
		end else begin
			tmp      = bcd_inc({1'b0, minutes_bcd});
			next_min = tmp[6:0]; // R9
		end
	end
	if (day_carry) begin
		if (days_bcd >= day_last)
			next_day = 6'h01; // R13
		else begin
			tmp      = bcd_inc({2'h0, days_bcd});
			next_day = tmp[5:0];
		end
		if (weekday == `LAST_WEEKDAY)
			next_wday = 3'h0; // R16
		else
			next_wday = weekday + 3'h1;
	end
end

////////////////////////////////////////////////////////////////////////////
// Registers, host writes and tick servicing

wire time_wr = i_wr_en && (i_addr >= `ADDR_SECONDS)
		&& (i_addr <= `ADDR_WEEKDAYS);
// A host write to the counters blocks that cycle like an access does
wire blocked = i_access_busy || time_wr;
wire advance = !blocked && (sec_event || pending);

always @(posedge i_mclk) begin
	if (i_rst) begin
		scratch_byte         <= `RST_SCRATCH; // R4
		seconds_bcd          <= `RST_SECONDS; // R5
		oscillator_halt_flag <= 1'b1; // R6
		minutes_bcd          <= `RST_MINUTES;
		hours_bcd            <= `RST_HOURS;
		days_bcd             <= `RST_DAYS; // R13
		weekday              <= `RST_WEEKDAY; // R16
		pending              <= 1'b0;
		minute_quarter       <= 2'h0;
		corr_left            <= 7'h00;
		corr_add             <= 1'b0;
	end else if (i_ce) begin
		// Only one tick is remembered while blocked
		if (blocked)
			pending <= pending | sec_event; // R17
		else
			pending <= pending & sec_event; // R17
		if (advance) begin
			seconds_bcd <= next_sec; // R20
			minutes_bcd <= next_min;
			hours_bcd   <= next_hour;
			days_bcd    <= next_day;
			weekday     <= next_wday;
			if (min_carry) begin
				minute_quarter <= minute_quarter + 2'h1;
				if (minute_quarter == `CORR_QUARTER_LAST) begin
					corr_left <= offset_mag; // R18
					corr_add  <= !i_offset[`SIGN_BIT];
				end
			end
		end
		if (corr_pulse && !(advance && min_carry
				&& minute_quarter == `CORR_QUARTER_LAST))
			corr_left <= corr_left - 7'h01; // R18
		if (i_wr_en) begin
			case (i_addr)
			`ADDR_SCRATCH:  scratch_byte <= i_wdata; // R4
			`ADDR_SECONDS:  seconds_bcd  <= i_wdata[6:0];
			`ADDR_MINUTES:  minutes_bcd  <= i_wdata[6:0];
			`ADDR_HOURS:    hours_bcd    <= i_wdata[5:0];
			`ADDR_DAYS:     days_bcd     <= i_wdata[5:0];
			`ADDR_WEEKDAYS: weekday      <= i_wdata[2:0];
			default: ;
			endcase
		end
		// A stopped oscillator wins over a clear in the same cycle
		if (!osc_ok)
			oscillator_halt_flag <= 1'b1; // R6 R7 R8
		else if (i_wr_en && i_addr == `ADDR_SECONDS)
			oscillator_halt_flag <= i_wdata[`HALT_BIT]; // R8
	end
end

////////////////////////////////////////////////////////////////////////////
// Read path; unused bits and unmapped addresses read zero

always @(posedge i_mclk) begin
	if (i_rst)
		o_rdata <= 8'h00;
	else if (i_ce && i_rd_en) begin
		case (i_addr)
		`ADDR_SCRATCH:  o_rdata <= scratch_byte;
		`ADDR_SECONDS:  o_rdata <= {oscillator_halt_flag, seconds_bcd};
		`ADDR_MINUTES:  o_rdata <= {1'b0, minutes_bcd}; // R9
		`ADDR_HOURS:    o_rdata <= {2'h0, hours_bcd}; // R11
		`ADDR_DAYS:     o_rdata <= {2'h0, days_bcd}; // R13
		`ADDR_WEEKDAYS: o_rdata <= {5'h00, weekday}; // R15
		default:        o_rdata <= 8'h00;
		endcase
	end
end

endmodule

// *** verif/rtc_core_checker.sv ***
// Port-level assertions for the timekeeping core
`timescale 1ns/10ps
module rtc_core_checker #(
	parameter TICK_CYCLES = 4
) (
	// Clock and reset
	input wire       i_mclk,
	input wire       i_rst,
	// Register access
	input wire       i_wr_en,
	input wire       i_rd_en,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire [7:0] o_rdata,
	// Status, control and outputs
	input wire       i_osc_running,
	input wire       i_correction_irq_enable,
	input wire       i_fast_mode,
	input wire       o_int_n,
	input wire       o_tick_1024hz,
	input wire       o_tick_1hz
);
	reg [7:0]  scr;
	reg [15:0] lowc;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Shadow of the scratch byte and length of the current low pulse
	always @(posedge i_mclk) begin
		scr  <= i_rst ? 8'h00 : (i_wr_en && i_addr == 8'h03) ? i_wdata : scr;
		lowc <= o_int_n ? 16'h0000 : lowc + 16'h0001;
	end
	scratch_read_a: assert property (
		i_rd_en && i_addr == 8'h03 |=> o_rdata == $past(scr))
		else $error("scratch readback wrong");
	sec_bcd_a: assert property (
		i_rd_en && i_addr == 8'h04 |=> o_rdata[6:4] <= 3'h5 &&
		o_rdata[3:0] <= 4'h9) else $error("seconds not BCD");
	min_top_zero_a: assert property (
		i_rd_en && i_addr == 8'h05 |=> !o_rdata[7])
		else $error("minutes bit 7 set");
	hour_top_zero_a: assert property (
		i_rd_en && i_addr == 8'h06 |=> o_rdata[7:6] == 2'h0)
		else $error("hours upper bits set");
	day_range_a: assert property (
		i_rd_en && i_addr == 8'h07 |=> o_rdata[7:6] == 2'h0 &&
		o_rdata[5:0] != 6'h00) else $error("day value invalid");
	wday_range_a: assert property (
		i_rd_en && i_addr == 8'h08 |=> o_rdata[7:3] == 5'h00 &&
		o_rdata[2:0] != 3'h7) else $error("weekday value invalid");
	halt_sticky_a: assert property (
		!i_osc_running[*6] ##0 (i_rd_en && i_addr == 8'h04) |=> o_rdata[7])
		else $error("halt flag clear while stopped");
	pulse_width_a: assert property (
		$rose(o_int_n) |-> lowc == TICK_CYCLES)
		else $error("correction pulse width wrong");
	int_gate_a: assert property (
		$fell(o_int_n) |-> $past(i_correction_irq_enable && i_fast_mode))
		else $error("pulse while disabled");
	base_tick_a: assert property (
		o_tick_1024hz |=> !o_tick_1024hz[*3])
		else $error("base tick disturbed");
	cover property (o_int_n ##1 !o_int_n);
	cover property (o_tick_1hz);
	cover property (i_rd_en && i_addr == 8'h04 ##1 o_rdata[7]);
endmodule

bind rtc_core rtc_core_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
	.i_mclk, .i_rst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata, .o_rdata,
	.i_osc_running, .i_correction_irq_enable, .i_fast_mode, .o_int_n,
	.o_tick_1024hz, .o_tick_1hz);

// *** verif/host_model.sv ***
// Host side of the register access: single-byte reads and writes
`timescale 1ns/10ps
module host_model (
	// Clock and returned data
	input  wire       i_mclk,
	input  wire [7:0] i_rdata,
	// Strobes towards the core
	output reg        o_wr_en,
	output reg        o_rd_en,
	output reg  [7:0] o_addr,
	output reg  [7:0] o_wdata,
	output reg        o_busy
);
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr  = 8'hFF;
		o_wdata = 8'hA5;
		o_busy  = 1'b0;
	end
	// Two cycles per byte, far inside the one-second limit
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge i_mclk);
		o_wr_en <= 1'b1;
		o_addr  <= a;
		o_wdata <= d;
		@(posedge i_mclk);
		o_wr_en <= 1'b0;
		// Released lines must not keep their last value
		o_addr  <= ~a;
		o_wdata <= ~d;
	end
	endtask
	task rd(input [7:0] a, output [7:0] d);
	begin
		@(posedge i_mclk);
		o_rd_en <= 1'b1;
		o_addr  <= a;
		@(posedge i_mclk);
		o_rd_en <= 1'b0;
		o_addr  <= ~a;
		#1 d = i_rdata;
	end
	endtask
	task hold(input b);
		@(posedge i_mclk) o_busy <= b;
	endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the timekeeping core
`timescale 1ns/10ps
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
	end \
end
module tb_top;
	reg       i_mclk = 1'b0;
	reg       i_rst = 1'b1;
	reg       mode_12h = 1'b0;
	reg       irq_en = 1'b0;
	reg       fast = 1'b0;
	reg       leap = 1'b0;
	reg       osc = 1'b0;
	reg [6:0] offset = 7'h02;
	reg [4:0] month = 5'h01;
	reg       pint = 1'b1;
	reg [7:0] v;
	reg       ce = 1'b1;
	wire      wr, rd, busy, int_n, t1hz, t1k, t64;
	integer   n1k = 0, n64 = 0;
	wire [7:0] addr, wdata, rdata;
	integer   seed = 91, miscompares = 0, samples_checked = 0;
	integer   falls = 0, s, m, h, d, w, i;
	always #25 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		pint <= int_n;
		if (pint && !int_n)
			falls++;
		if (t1k)
			n1k++;
		if (t64)
			n64++;
	end
	rtc_core #(.TICK_CYCLES(4)) i_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce),
		.i_access_busy(busy), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
		.i_wdata(wdata), .o_rdata(rdata), .i_mode_12h(mode_12h),
		.i_correction_irq_enable(irq_en), .i_fast_mode(fast),
		.i_offset(offset), .i_leap_year(leap), .i_month_bcd(month),
		.i_osc_running(osc), .o_int_n(int_n), .o_tick_1024hz(t1k),
		.o_tick_64hz(t64), .o_tick_1hz(t1hz));
	host_model i_host (.i_mclk(i_mclk), .i_rdata(rdata), .o_wr_en(wr),
		.o_rd_en(rd), .o_addr(addr), .o_wdata(wdata), .o_busy(busy));
	////////////////////////////////////////////////////////////////////////
	function [7:0] bcd(input integer n);
		bcd = ((n / 10) << 4) | (n % 10);
	endfunction
	// Model keeps 24-hour time; shown in the selected format
	function [7:0] hr(input integer n);
		if (!mode_12h)
			hr = bcd(n);
		else
			hr = bcd(n % 12 == 0 ? 12 : n % 12) | (n >= 12 ? 8'h20 : 8'h00);
	endfunction
	task conclude;
	begin
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task mtick;
	begin
		s = s + 1;
		m = m + s / 60;
		s = s % 60;
		h = h + m / 60;
		m = m % 60;
		d = d + h / 24;
		w = (w + h / 24) % 7;
		h = h % 24;
		if (d > (month == 5'h02 ? 28 + leap : 31))
			d = 1;
	end
	endtask
	task waitsec;
		integer k;
	begin
		k = 0;
		do begin
			@(posedge i_mclk);
			#1 k++;
		end while (t1hz !== 1'b1 && k < 6000);
		if (t1hz !== 1'b1) begin
			miscompares++;
			conclude;
		end
		mtick;
	end
	endtask
	task rc(input [7:0] a, input [7:0] e);
	begin
		i_host.rd(a, v);
		`CHK(v, e)
	end
	endtask
	// Starts just after a tick so no tick is left pending by the writes
	task setall(input integer a, b, c, e, f);
	begin
		waitsec;
		s = a;
		m = b;
		h = c;
		d = e;
		w = f;
		i_host.hold(1'b1);
		i_host.wr(8'h04, bcd(s));
		i_host.wr(8'h05, bcd(m));
		i_host.wr(8'h06, hr(h));
		i_host.wr(8'h07, bcd(d));
		i_host.wr(8'h08, bcd(w));
		i_host.hold(1'b0);
	end
	endtask
	task chkall;
	begin
		waitsec;
		rc(8'h04, bcd(s));
		rc(8'h05, bcd(m));
		rc(8'h06, hr(h));
		rc(8'h07, bcd(d));
		rc(8'h08, bcd(w));
	end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		rc(8'h03, 8'h00);
		rc(8'h04, 8'h80);
		rc(8'h05, 8'h00);
		rc(8'h06, 8'h00);
		rc(8'h07, 8'h01);
		rc(8'h08, 8'h06);
		rc(8'h0A, 8'h00);
		i_host.wr(8'h04, 8'h00);
		rc(8'h04, 8'h80);
		for (i = 0; i < 2; i++) begin
			@(posedge i_mclk) osc <= 1'b1;
			repeat (8) @(posedge i_mclk);
			i_host.wr(8'h04, 8'h00);
			rc(8'h04, 8'h00);
			@(posedge i_mclk) osc <= i[0];
			repeat (8) @(posedge i_mclk);
			rc(8'h04, {~i[0], 7'h00});
		end
		for (i = 0; i < 4; i++) begin
			v = $random(seed);
			i_host.wr(8'h03, v);
			rc(8'h03, v);
		end
		@(posedge i_mclk) month <= 5'h02;
		for (i = 0; i < 3; i++) begin
			@(posedge i_mclk) leap <= i > 0;
			@(posedge i_mclk) mode_12h <= i == 2;
			// Uncorrected second: full count of derived ticks
			if (i == 0) begin
				waitsec;
				n1k = 0;
				n64 = 0;
				waitsec;
				`CHK(n1k, 1024)
				`CHK(n64, 64)
			end
			setall(59, 59, i == 2 ? 11 : 23, 28, 6);
			chkall;
		end
		@(posedge i_mclk) mode_12h <= 1'b0;
		setall(10, 0, 0, 1, 0);
		i_host.hold(1'b1);
		repeat (5000) @(posedge i_mclk);
		i_host.hold(1'b0);
		mtick;
		rc(8'h04, bcd(s));
		@(posedge i_mclk) fast <= 1'b1;
		for (i = 0; i < 5; i++) begin
			@(posedge i_mclk) irq_en <= i > 0;
			i_host.wr(8'h04, 8'h59);
			waitsec;
			falls = 0;
			if (i == 0 || i == 4) begin
				repeat (3) waitsec;
				`CHK(falls, i ? 2 : 0)
			end
		end
		conclude;
	end
endmodule
